// >>> logic/acsp_pkg.sv
// Constants shared by the audio control serial port.
// Assumes a single system clock; the serial pins are asynchronous to it.
package acsp_pkg;

    // Frame layout.
    localparam logic [1:0] ADDR_MATCH = 2'h2;
    localparam logic [3:0] WORD_BITS = 4'h9;
    localparam int SYNC_STAGES = 3;

    // Function codes carried in the top three bits of the word.
    localparam logic [2:0] FN_INSEL = 3'h0;
    localparam logic [2:0] FN_BASS = 3'h1;
    localparam logic [2:0] FN_TREBLE = 3'h2;
    localparam logic [2:0] FN_VOLUME = 3'h3;
    localparam logic [2:0] FN_RF = 3'h4;
    localparam logic [2:0] FN_LF = 3'h5;
    localparam logic [2:0] FN_RR = 3'h6;
    localparam logic [2:0] FN_LR = 3'h7;

    // Decode limits, in 2 dB steps of one code each.
    localparam logic [5:0] VOL_TOP_CODE = 6'h28;
    localparam logic [6:0] VOL_RANGE_DB = 7'h50;
    localparam logic [3:0] TONE_TOP_CODE = 4'hc;
    localparam logic [4:0] TONE_OFFSET_DB = 5'h0c;
    localparam logic [4:0] FAD_TOP_CODE = 5'h14;
    localparam logic [5:0] FAD_RANGE_DB = 6'h28;

    // Reset values: volume and faders at minimum, tone flat, inputs open.
    localparam logic [5:0] RST_VOLUME = 6'h00;
    localparam logic [5:0] RST_FADER = 6'h00;
    localparam logic [5:0] RST_TONE = 6'h06;
    localparam logic [5:0] RST_INSEL = 6'h00;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_DATA = 4'h4,
        ST_SKIP = 4'h8
    } acsp_state_e;

endpackage : acsp_pkg

// >>> logic/acsp_pin_sync.sv
// Three-stage synchroniser for one serial pin, with level and edge pulses.
// Assumes the pin is asynchronous to clk and changes far slower than clk.
`timescale 1ns/1ps
module acsp_pin_sync #(
    parameter logic RST_LVL = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Pin side.
    input wire logic pin,
    // Filtered level and one-cycle edges.
    output logic lvl,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic [2:0] sh;
        logic lvl;
        logic rise;
        logic fall;
    } acsp_sync_s;

    acsp_sync_s s_r;
    acsp_sync_s s_nxt;

    // A change counts only once the second and third stages agree.
    always_comb begin
        s_nxt = s_r;
        s_nxt.sh = {s_r.sh[1:0], pin};
        s_nxt.rise = 1'b0;
        s_nxt.fall = 1'b0;
        if (s_r.sh[2] == s_r.sh[1] && s_r.sh[1] != s_r.lvl) begin
            s_nxt.lvl = s_r.sh[1];
            s_nxt.rise = s_r.sh[1];
            s_nxt.fall = !s_r.sh[1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= {{3{RST_LVL}}, RST_LVL, 1'b0, 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lvl = s_r.lvl;
    assign rise = s_r.rise;
    assign fall = s_r.fall;

endmodule : acsp_pin_sync

// >>> logic/acsp_decode.sv
// Combinational decode of the latched setting codes into gains.
// Assumes codes come straight from the setting latches; caller registers outputs.
`timescale 1ns/1ps
module acsp_decode (
    // Latched codes.
    input wire logic [5:0] vol_code,
    input wire logic [5:0] bass_code,
    input wire logic [5:0] treble_code,
    input wire logic [5:0] insel_code,
    input wire logic [5:0] rf_code,
    input wire logic [5:0] lf_code,
    input wire logic [5:0] rr_code,
    input wire logic [5:0] lr_code,
    // Decoded values.
    output logic [6:0] vol_atten,
    output logic signed [4:0] bass_db,
    output logic signed [4:0] treble_db,
    output logic [3:0] insel_onehot,
    output logic [5:0] rf_atten,
    output logic [5:0] lf_atten,
    output logic [5:0] rr_atten,
    output logic [5:0] lr_atten
);

    logic [3:0][5:0] fc;
    logic [3:0][5:0] fa;
    logic [3:0] bc;
    logic [3:0] tc;

    // Codes above the top step clamp there, since such codes are undefined.
    assign vol_atten = (vol_code >= acsp_pkg::VOL_TOP_CODE) ? 7'h00 :
        7'(acsp_pkg::VOL_RANGE_DB - {vol_code, 1'b0});
    assign bc = (bass_code[3:0] > acsp_pkg::TONE_TOP_CODE) ? acsp_pkg::TONE_TOP_CODE : bass_code[3:0];
    assign tc = (treble_code[3:0] > acsp_pkg::TONE_TOP_CODE) ? acsp_pkg::TONE_TOP_CODE : treble_code[3:0];
    assign bass_db = 5'({bc, 1'b0} - acsp_pkg::TONE_OFFSET_DB);
    assign treble_db = 5'({tc, 1'b0} - acsp_pkg::TONE_OFFSET_DB);

    assign fc = {lr_code, rr_code, lf_code, rf_code};

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_fad
            assign fa[i] = (fc[i][4:0] >= acsp_pkg::FAD_TOP_CODE) ? 6'h00 :
                6'(acsp_pkg::FAD_RANGE_DB - {fc[i][4:0], 1'b0});
            assign insel_onehot[i] = !insel_code[3] && insel_code[2:0] == 3'(i + 1);
        end
    endgenerate

    assign rf_atten = fa[0];
    assign lf_atten = fa[1];
    assign rr_atten = fa[2];
    assign lr_atten = fa[3];

endmodule : acsp_decode

// >>> logic/acsp_core.sv
// Serial control port of a stereo tone, volume, fader and selector chip.
// Assumes a controller drives strobe, serial clock and data far slower than clk.
`timescale 1ns/1ps
module acsp_core (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Serial pins, all asynchronous to clk.
    input wire logic strobe_n,
    input wire logic sclk,
    input wire logic sdata,
    // Setting latches.
    output logic [5:0] input_selector,
    output logic [5:0] bass_tone,
    output logic [5:0] treble_tone,
    output logic [5:0] master_volume,
    output logic [5:0] right_front_attenuator,
    output logic [5:0] left_front_attenuator,
    output logic [5:0] right_rear_attenuator,
    output logic [5:0] left_rear_attenuator,
    // Decoded settings.
    output logic [6:0] volume_atten_db,
    output logic signed [4:0] bass_gain_db,
    output logic signed [4:0] treble_gain_db,
    output logic [3:0] input_onehot,
    output logic [5:0] rf_atten_db,
    output logic [5:0] lf_atten_db,
    output logic [5:0] rr_atten_db,
    output logic [5:0] lr_atten_db
);

    typedef struct packed {
        acsp_pkg::acsp_state_e st;
        logic acnt;
        logic abit;
        logic [8:0] sr;
        logic [3:0] dcnt;
        logic [7:0][5:0] lat;
        logic [6:0] vol;
        logic [4:0] bass;
        logic [4:0] treb;
        logic [3:0] sel;
        logic [3:0][5:0] fad;
    } acsp_core_s;

    acsp_core_s c_r;
    acsp_core_s c_nxt;

    logic stb_lvl;
    logic stb_rise;
    logic stb_fall;
    logic sck_rise;
    logic sd_lvl;
    logic [6:0] d_vol;
    logic [4:0] d_bass;
    logic [4:0] d_treb;
    logic [3:0] d_sel;
    logic [3:0][5:0] d_fad;

    // The data pin takes the same path as the clock pin, so they stay aligned.
    acsp_pin_sync #(.RST_LVL(1'b1)) u_stb (
        .clk(clk),
        .rst(rst),
        .pin(strobe_n),
        .lvl(stb_lvl),
        .rise(stb_rise),
        .fall(stb_fall)
    );

    acsp_pin_sync #(.RST_LVL(1'b0)) u_sck (
        .clk(clk),
        .rst(rst),
        .pin(sclk),
        .lvl(),
        .rise(sck_rise),
        .fall()
    );

    acsp_pin_sync #(.RST_LVL(1'b0)) u_sd (
        .clk(clk),
        .rst(rst),
        .pin(sdata),
        .lvl(sd_lvl),
        .rise(),
        .fall()
    );

    acsp_decode u_dec (
        .vol_code(c_r.lat[acsp_pkg::FN_VOLUME]),
        .bass_code(c_r.lat[acsp_pkg::FN_BASS]),
        .treble_code(c_r.lat[acsp_pkg::FN_TREBLE]),
        .insel_code(c_r.lat[acsp_pkg::FN_INSEL]),
        .rf_code(c_r.lat[acsp_pkg::FN_RF]),
        .lf_code(c_r.lat[acsp_pkg::FN_LF]),
        .rr_code(c_r.lat[acsp_pkg::FN_RR]),
        .lr_code(c_r.lat[acsp_pkg::FN_LR]),
        .vol_atten(d_vol),
        .bass_db(d_bass),
        .treble_db(d_treb),
        .insel_onehot(d_sel),
        .rf_atten(d_fad[0]),
        .lf_atten(d_fad[1]),
        .rr_atten(d_fad[2]),
        .lr_atten(d_fad[3])
    );

    always_comb begin
        c_nxt = c_r;
        c_nxt.vol = d_vol;
        c_nxt.bass = d_bass;
        c_nxt.treb = d_treb;
        c_nxt.sel = d_sel;
        c_nxt.fad = d_fad;
        if (stb_fall) begin
            c_nxt.st = acsp_pkg::ST_ADDR;
            c_nxt.acnt = 1'b0;
            c_nxt.dcnt = 4'h0;
        end else if (stb_rise) begin
            // A clock edge seen together with the strobe rise is dropped.
            if (c_r.st == acsp_pkg::ST_DATA && c_r.dcnt == acsp_pkg::WORD_BITS) begin
                c_nxt.lat[c_r.sr[8:6]] = c_r.sr[5:0];
            end
            c_nxt.st = acsp_pkg::ST_IDLE;
        end else if (sck_rise && !stb_lvl) begin
            case (c_r.st)
                acsp_pkg::ST_ADDR: begin
                    if (!c_r.acnt) begin
                        c_nxt.abit = sd_lvl;
                        c_nxt.acnt = 1'b1;
                    end else if ({c_r.abit, sd_lvl} == acsp_pkg::ADDR_MATCH) begin
                        c_nxt.st = acsp_pkg::ST_DATA;
                    end else begin
                        c_nxt.st = acsp_pkg::ST_SKIP;
                    end
                end
                acsp_pkg::ST_DATA: begin
                    // Older bits fall off the top, so padding is harmless.
                    c_nxt.sr = {c_r.sr[7:0], sd_lvl};
                    if (c_r.dcnt != acsp_pkg::WORD_BITS) begin
                        c_nxt.dcnt = c_r.dcnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Latches keep their value; only the strobe rise of an addressed frame writes.
    always_ff @(posedge clk) begin
        if (rst) begin
            c_r.st <= acsp_pkg::ST_IDLE;
            c_r.acnt <= 1'b0;
            c_r.abit <= 1'b0;
            c_r.sr <= 9'h000;
            c_r.dcnt <= 4'h0;
            c_r.lat <= {acsp_pkg::RST_FADER, acsp_pkg::RST_FADER, acsp_pkg::RST_FADER,
                acsp_pkg::RST_FADER, acsp_pkg::RST_VOLUME, acsp_pkg::RST_TONE,
                acsp_pkg::RST_TONE, acsp_pkg::RST_INSEL};
            c_r.vol <= acsp_pkg::VOL_RANGE_DB;
            c_r.bass <= 5'h00;
            c_r.treb <= 5'h00;
            c_r.sel <= 4'h0;
            c_r.fad <= {4{acsp_pkg::FAD_RANGE_DB}};
        end else begin
            c_r <= c_nxt;
        end
    end

    assign input_selector = c_r.lat[acsp_pkg::FN_INSEL];
    assign bass_tone = c_r.lat[acsp_pkg::FN_BASS];
    assign treble_tone = c_r.lat[acsp_pkg::FN_TREBLE];
    assign master_volume = c_r.lat[acsp_pkg::FN_VOLUME];
    assign right_front_attenuator = c_r.lat[acsp_pkg::FN_RF];
    assign left_front_attenuator = c_r.lat[acsp_pkg::FN_LF];
    assign right_rear_attenuator = c_r.lat[acsp_pkg::FN_RR];
    assign left_rear_attenuator = c_r.lat[acsp_pkg::FN_LR];
    assign volume_atten_db = c_r.vol;
    assign bass_gain_db = c_r.bass;
    assign treble_gain_db = c_r.treb;
    assign input_onehot = c_r.sel;
    assign rf_atten_db = c_r.fad[0];
    assign lf_atten_db = c_r.fad[1];
    assign rr_atten_db = c_r.fad[2];
    assign lr_atten_db = c_r.fad[3];

    a_addr_clear: assert property (@(posedge clk) disable iff (rst)
        stb_fall |=> c_r.st == acsp_pkg::ST_ADDR && !c_r.acnt)
        else $error("Strobe fall did not restart addressing.");

    a_addr_match: assert property (@(posedge clk) disable iff (rst)
        (c_r.st == acsp_pkg::ST_ADDR && c_r.acnt && sck_rise && !stb_lvl && !stb_fall
        && !stb_rise && c_r.abit && !sd_lvl) |=> c_r.st == acsp_pkg::ST_DATA && c_r.dcnt == 4'h0)
        else $error("Matching address did not open the frame.");

    a_addr_reject: assert property (@(posedge clk) disable iff (rst)
        (c_r.st == acsp_pkg::ST_ADDR && c_r.acnt && sck_rise && !stb_lvl && !stb_fall
        && !stb_rise && {c_r.abit, sd_lvl} != 2'h2) |=> c_r.st == acsp_pkg::ST_SKIP)
        else $error("Foreign address was not ignored.");

    a_skip_hold: assert property (@(posedge clk) disable iff (rst)
        c_r.st == acsp_pkg::ST_SKIP |=> $stable(c_r.lat))
        else $error("Settings changed in a foreign frame.");

    a_shift_bit: assert property (@(posedge clk) disable iff (rst)
        (c_r.st == acsp_pkg::ST_DATA && sck_rise && !stb_lvl && !stb_fall && !stb_rise)
        |=> c_r.sr == {$past(c_r.sr[7:0]), $past(sd_lvl)})
        else $error("Data bit was not shifted in.");

    a_lat_cause: assert property (@(posedge clk) disable iff (rst)
        c_r.lat != $past(c_r.lat) |-> $past(stb_rise && c_r.st == acsp_pkg::ST_DATA))
        else $error("Setting changed outside a transfer.");

    a_lat_write: assert property (@(posedge clk) disable iff (rst)
        (stb_rise && c_r.st == acsp_pkg::ST_DATA && c_r.dcnt == 4'h9)
        |=> c_r.lat[$past(c_r.sr[8:6])] == $past(c_r.sr[5:0]) && c_r.st == acsp_pkg::ST_IDLE)
        else $error("Word was not moved into its latch.");

    a_stop_rise: assert property (@(posedge clk) disable iff (rst)
        (stb_rise && !stb_fall) |=> c_r.st == acsp_pkg::ST_IDLE ##1 $stable(c_r.sr))
        else $error("Shifting continued after strobe rise.");

    a_vol_min: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_VOLUME] == 6'h00) [*2] |-> c_r.vol == 7'h50)
        else $error("Volume code zero is not -80 dB.");

    a_tone_flat: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_TREBLE][3:0] == 4'h6) [*2] |-> c_r.treb == 5'h00)
        else $error("Treble flat code is not 0 dB.");

    a_fader_top: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_LR][4:1] == 4'ha) [*2] |-> c_r.fad[3] == 6'h00)
        else $error("Fader top code is not 0 dB.");

    a_sel_open: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_INSEL][3:0] == 4'h0) [*2] |-> c_r.sel == 4'h0)
        else $error("Open code selected an input.");

    a_step_2db: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_BASS][3:0] == 4'h7) [*2] |-> c_r.bass == 5'h02)
        else $error("One bass step is not 2 dB.");

    a_short_drop: assert property (@(posedge clk) disable iff (rst)
        (stb_rise && c_r.st == acsp_pkg::ST_DATA && c_r.dcnt != 4'h9) |=> $stable(c_r.lat))
        else $error("A short frame changed a setting.");

    a_count_step: assert property (@(posedge clk) disable iff (rst)
        (c_r.st == acsp_pkg::ST_DATA && sck_rise && !stb_lvl && !stb_fall && !stb_rise
        && c_r.dcnt != 4'h9) |=> c_r.dcnt == $past(c_r.dcnt) + 4'h1)
        else $error("Word bit count did not advance.");

    a_foreign_hold: assert property (@(posedge clk) disable iff (rst)
        (stb_rise && c_r.st != acsp_pkg::ST_DATA) |=> $stable(c_r.lat))
        else $error("Strobe rise wrote without an address match.");

    a_idle_hold: assert property (@(posedge clk) disable iff (rst)
        c_r.st == acsp_pkg::ST_IDLE |=> $stable(c_r.sr))
        else $error("Bits shifted while the strobe was high.");

    a_other_hold: assert property (@(posedge clk) disable iff (rst)
        (stb_rise && c_r.st == acsp_pkg::ST_DATA && c_r.dcnt == 4'h9 && c_r.sr[8:6] != acsp_pkg::FN_VOLUME)
        |=> $stable(c_r.lat[acsp_pkg::FN_VOLUME]))
        else $error("Volume changed on a write to another function.");

    a_vol_mid: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_VOLUME] == 6'h14) [*2] |-> c_r.vol == 7'h28)
        else $error("Volume code twenty is not -40 dB.");

    a_tone_boost: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_TREBLE][3:0] == 4'hc) [*2] |-> c_r.treb == 5'h0c)
        else $error("Treble top code is not +12 dB.");

    a_tone_cut: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_BASS][3:0] == 4'h0) [*2] |-> c_r.bass == 5'h14)
        else $error("Bass bottom code is not -12 dB.");

    a_fader_min: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_RF][4:0] == 5'h00) [*2] |-> c_r.fad[0] == 6'h28)
        else $error("Fader bottom code is not -40 dB.");

    a_fader_mid: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_LF][4:0] == 5'h0a) [*2] |-> c_r.fad[1] == 6'h14)
        else $error("Fader middle code is not -20 dB.");

    a_sel_input: assert property (@(posedge clk) disable iff (rst)
        (c_r.lat[acsp_pkg::FN_INSEL][3:0] == 4'h4) [*2] |-> c_r.sel == 4'h8)
        else $error("Input code four did not pick input four.");

endmodule : acsp_core

// >>> verification/acsp_host_model.sv
// Behavioural controller that frames words onto the three-wire serial bus.
// Assumes the caller starts each frame just after a system clock edge.
`timescale 1ns/1ps
module acsp_host_model (
    // Serial pins towards the device.
    output logic strobe_n,
    output logic sclk,
    output logic sdata
);
    initial begin
        strobe_n = 1'b1;
        sclk = 1'b0;
        sdata = 1'b0;
    end

    // Sends n bits MSB first; tail raises the strobe with the clock high and adds one stray clock.
    task automatic send(input logic [47:0] bits, input int n, input bit tail);
        int i;
        strobe_n = 1'b0;
        #100;
        for (i = n - 1; i >= 0; i--) begin
            sdata = bits[i];
            #80 sclk = 1'b1;
            #80 sclk = tail && i == 0;
        end
        // Released data shows the inverse so a stale bit cannot pass for a real one.
        sdata = ~sdata;
        #80 strobe_n = 1'b1;
        if (tail) begin
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #220;
    endtask : send
endmodule : acsp_host_model

// >>> verification/testbench.sv
// Self-checking bench for the serial control port core.
// Assumes the host model drives the pins; expected values come from local functions.
`timescale 1ns/1ps
module testbench;
    logic clk, rst, strobe_n, sclk, sdata;
    logic [5:0] input_selector, bass_tone, treble_tone, master_volume;
    logic [5:0] right_front_attenuator, left_front_attenuator, right_rear_attenuator, left_rear_attenuator;
    logic [6:0] volume_atten_db;
    logic signed [4:0] bass_gain_db, treble_gain_db;
    logic [3:0] input_onehot;
    logic [5:0] rf_atten_db, lf_atten_db, rr_atten_db, lr_atten_db;
    logic [47:0] prev_r;
    logic [5:0] want [8];
    logic [5:0] lo [8] = '{6'h30, 6'h30, 6'h30, 6'h00, 6'h20, 6'h20, 6'h20, 6'h20};
    logic [5:0] hi [8] = '{6'h04, 6'h0c, 6'h3c, 6'h29, 6'h35, 6'h14, 6'h35, 6'h15};
    int mismatches = 0;
    int checked = 0;
    wire logic [47:0] lat = {input_selector, bass_tone, treble_tone, master_volume,
        right_front_attenuator, left_front_attenuator, right_rear_attenuator, left_rear_attenuator};

    acsp_core u_dut (.clk, .rst, .strobe_n, .sclk, .sdata, .input_selector, .bass_tone, .treble_tone,
        .master_volume, .right_front_attenuator, .left_front_attenuator, .right_rear_attenuator,
        .left_rear_attenuator, .volume_atten_db, .bass_gain_db, .treble_gain_db, .input_onehot,
        .rf_atten_db, .lf_atten_db, .rr_atten_db, .lr_atten_db);
    acsp_host_model u_host (.strobe_n, .sclk, .sdata);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] wanted);
        checked++;
        if (seen !== wanted) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, wanted);
        end
    endtask : check

    task automatic complete_run();
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // Expected decoded value of one function; undefined selector codes pick no input, others clamp to the end of their range.
    function automatic logic [6:0] dec(input logic [2:0] fn, input logic [5:0] v);
        case (fn)
            3'h0: dec = (v[3] || v[2:0] > 3'h4 || v[2:0] == 3'h0) ? 7'h00 : 7'h01 << (v[2:0] - 3'h1);
            3'h1, 3'h2: dec = {2'h0, (v[3:0] > 4'hc) ? 5'h0c : 5'({v[3:0], 1'b0}) - 5'h0c};
            3'h3: dec = (v >= 6'h28) ? 7'h00 : 7'h50 - 7'({v, 1'b0});
            default: dec = (v[4:0] >= 5'h14) ? 7'h00 : 7'h28 - 7'({v[4:0], 1'b0});
        endcase
    endfunction : dec

    function automatic logic [5:0] legal(input logic [2:0] fn);
        logic [5:0] r;
        r = 6'($urandom);
        case (fn)
            3'h0: legal = {r[5:4], 1'b0, 3'($urandom % 5)};
            3'h1, 3'h2: legal = {r[5:4], 4'($urandom % 13)};
            3'h3: legal = 6'($urandom % 42);
            default: legal = {r[5], 5'($urandom % 22)};
        endcase
    endfunction : legal

    task automatic check_all();
        check(64'(lat), 64'({want[0], want[1], want[2], want[3], want[4], want[5], want[6], want[7]}));
        check(64'(input_onehot), 64'(dec(3'h0, want[0])));
        check(64'({bass_gain_db}), 64'(dec(3'h1, want[1])));
        check(64'({treble_gain_db}), 64'(dec(3'h2, want[2])));
        check(64'(volume_atten_db), 64'(dec(3'h3, want[3])));
        check(64'(rf_atten_db), 64'(dec(3'h4, want[4])));
        check(64'(lf_atten_db), 64'(dec(3'h5, want[5])));
        check(64'(rr_atten_db), 64'(dec(3'h6, want[6])));
        check(64'(lr_atten_db), 64'(dec(3'h7, want[7])));
    endtask : check_all

    // Address, random filler bits, then function code and value.
    task automatic frame(input logic [1:0] ad, input logic [2:0] fn, input logic [5:0] v, input int xtra);
        logic [47:0] b;
        b = (48'(ad) << (9 + xtra)) | ((48'($urandom) << 9) & ~(48'hffffffffffff << (9 + xtra))) | 48'({fn, v});
        u_host.send(b, 11 + xtra, 1'($urandom));
        if (ad == 2'h2) want[fn] = v;
        check_all();
    endtask : frame

    // Settings must never move while the strobe is low.
    always @(posedge clk) begin
        if (!rst && !strobe_n) check(64'(lat), 64'(prev_r));
        prev_r <= lat;
    end

    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    initial begin
        int i, fn, r;
        rst = 1'b1;
        r = $urandom(32'h7726);
        for (i = 0; i < 8; i++) want[i] = (i == 1 || i == 2) ? 6'h06 : 6'h00;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk);
        #1 check_all();
        for (fn = 0; fn < 8; fn++) begin
            frame(2'h2, 3'(fn), lo[fn], 0);
            frame(2'h2, 3'(fn), hi[fn], 0);
        end
        frame(2'h2, 3'h1, 6'h37, 3);
        frame(2'h2, 3'h3, 6'h14, 1);
        frame(2'h2, 3'h5, 6'h2a, 2);
        for (i = 0; i < 40; i++) begin
            fn = $urandom % 8;
            frame(2'h2, 3'(fn), legal(3'(fn)), $urandom % 21);
        end
        // A wrong address after a good frame must be refused afresh.
        for (i = 0; i < 8; i++) frame(2'(i), 3'(i + 2), legal(3'(i + 2)), i);
        // Too few bits after the address writes nothing.
        u_host.send(48'h2ff, 10, 1'b0);
        check_all();
        // Leave the inputs open so a shared select output stays free.
        frame(2'h2, 3'h0, 6'h00, 0);
        complete_run();
    end
endmodule : testbench
